// >>> otp_policy_pkg.sv
/*
  Shared constants for the OTP security lock policy block.
  Assumes a single 250 MHz clock and a 32-bit security word in OTP.
*/
package otp_policy_pkg;
  // Security word bit positions
  localparam int unsigned BIT_NO_TAP = 0;
  localparam int unsigned BIT_NO_LINK = 1;
  localparam int unsigned BIT_SEC_BOOT = 5;
  localparam int unsigned BIT_REDUNDANT = 7;
  localparam int unsigned BIT_SECT_LOCK_LO = 8;
  localparam int unsigned BIT_MASTER_LOCK = 12;
  localparam int unsigned BIT_NO_TAP_OTP = 13;
  localparam int unsigned BIT_NO_DEBUG = 14;
  localparam int unsigned USER_LO = 15;
  localparam int unsigned USER_HI = 21;
  localparam int unsigned UID_LO = 22;
  localparam int unsigned UID_HI = 31;
  localparam int unsigned USER_W = USER_HI - USER_LO + 1;
  localparam int unsigned UID_W = UID_HI - UID_LO + 1;
  localparam int unsigned SECTORS = 4;

  // Tile port resource identifiers
  localparam logic [23:0] RES_OTP_DATA = 24'h200100;
  localparam logic [23:0] RES_OTP_CTRL = 24'h100300;
  localparam int unsigned CTRL_W = 16;
  localparam int unsigned CTRL_SEC_ROW = 15;
  localparam int unsigned STAT_VALID = 0;
  localparam int unsigned STAT_REFUSED = 1;

  // OTP geometry and reset values
  localparam int unsigned OTP_AW = 11;
  localparam logic [10:0] SEC_WORD_ADDR = 11'h7ff;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  // Used when the word is not read in time: every protection on except boot from OTP (bit 5)
  localparam logic [31:0] WORD_FAILSAFE = 32'h0000_7f03;

  // Boot deadline after reset release
  localparam int unsigned INIT_TIME_US = 150;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned INIT_CYCLES = INIT_TIME_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    S_LOCK = 2'b00,
    S_READ = 2'b01,
    S_RUN = 2'b11
  } boot_state_e;
endpackage

// >>> otp_policy_if.sv
/*
  Carrier for the decoded security word between boot sequencer and policy.
  Assumes both ends share one clock.
*/
interface otp_policy_if;
  logic [31:0] sec_word;
  logic valid;
  logic boot_pulse;
  modport seq (output sec_word, output valid, output boot_pulse);
  modport pol (input sec_word, input valid, input boot_pulse);
endinterface

// >>> otp_boot_seq.sv
/*
  Boot sequencer: waits for clock lock, reads the security word, starts boot.
  Assumes the OTP read port answers with a one-cycle valid pulse.
*/
module otp_boot_seq
  import otp_policy_pkg::*;
#(
  parameter int unsigned INIT_LIMIT = INIT_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Clock generator
  input wire logic pll_lock_i,
  // OTP read port
  output logic otp_rd_req_o,
  output logic [OTP_AW-1:0] otp_rd_addr_o,
  input wire logic [31:0] otp_rd_data_i,
  input wire logic otp_rd_valid_i,
  // Decoded policy
  otp_policy_if.seq pol
);
  boot_state_e state;
  logic lock_meta;
  logic lock_sync;
  logic [$clog2(INIT_LIMIT+1)-1:0] init_cnt;
  logic deadline;

  // Lock arrives from another clock source
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
    end else begin
      lock_meta <= pll_lock_i;
      lock_sync <= lock_meta;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      init_cnt <= '0;
    end else if (state != S_RUN) begin
      init_cnt <= init_cnt + 1'b1;
    end
  end
  assign deadline = (init_cnt >= $bits(init_cnt)'(INIT_LIMIT - 2));

  // wait for lock, read word before boot
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= S_LOCK;
      pol.sec_word <= WORD_RESET;
      pol.valid <= 1'b0;
      pol.boot_pulse <= 1'b0;
    end else begin
      pol.boot_pulse <= 1'b0;
      case (state)
        S_LOCK: begin
          if (lock_sync) begin
            state <= S_READ;
          end else if (deadline) begin
            state <= S_RUN;
            pol.sec_word <= WORD_FAILSAFE;
            pol.valid <= 1'b1;
            pol.boot_pulse <= 1'b1;
          end
        end
        S_READ: begin
          if (otp_rd_valid_i || deadline) begin
            state <= S_RUN;
            pol.sec_word <= otp_rd_valid_i ? otp_rd_data_i : WORD_FAILSAFE;
            pol.valid <= 1'b1;
            pol.boot_pulse <= 1'b1;
          end
        end
        S_RUN: begin
          state <= S_RUN;
        end
        default: begin
          state <= S_LOCK;
        end
      endcase
    end
  end

  assign otp_rd_req_o = (state == S_READ);
  assign otp_rd_addr_o = SEC_WORD_ADDR;
endmodule

// >>> otp_security_lock_policy.sv
/*
  OTP security lock policy: decodes the security word and gates debug,
  link access, the debug request pin and OTP programming.
  Assumes test-port and switch requests are already on clk_i.
*/
// Function
// - Security bit 0 blocks all test-port access to tile state and memory.
// - Security bit 1 refuses switch requests from other tiles to processor state.
// - Security bit 5 forces execution start at OTP address zero.
// - Security bit 7 enables the spare redundant OTP rows.
// - Bits 8 to 11 lock OTP sectors 0 to 3 against programming.
// - Bit 12 rejects all OTP programming, security word included.
// - Bit 13 blocks test-port OTP reads and writes.
// - Bit 14 makes the device ignore the external debug request pin.
// - Bits 21 to 15 are readable general-purpose user data.
// - Bits 31 to 22 extend the test-port user identity code.
// - OTP reached through data port 0x200100 and 16-bit control port 0x100300.
// - Global reset is active low and asserts asynchronously.
// - After reset, wait for clock lock before booting; without lock by the deadline the sequencer boots anyway with WORD_FAILSAFE.
// - Booting begins within 150 microseconds of reset release.
module otp_security_lock_policy
  import otp_policy_pkg::*;
#(
  parameter int unsigned INIT_LIMIT = INIT_CYCLES,
  parameter logic [31:0] UID_BASE = 32'h0000_0001 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Clock generator and pins
  input wire logic pll_lock_i,
  input wire logic debug_req_pin_i,
  // OTP array
  output logic otp_rd_req_o,
  output logic [OTP_AW-1:0] otp_rd_addr_o,
  input wire logic [31:0] otp_rd_data_i,
  input wire logic otp_rd_valid_i,
  output logic otp_prog_req_o,
  output logic otp_prog_sec_row_o,
  output logic [OTP_AW-1:0] otp_prog_addr_o,
  output logic [31:0] otp_prog_data_o,
  output logic otp_redundancy_en_o,
  // Boot control
  output logic boot_start_o,
  output logic boot_from_otp_o,
  output logic debug_req_o,
  // Test port
  input wire logic tap_tile_req_i,
  output logic tap_tile_grant_o,
  input wire logic tap_otp_rd_i,
  input wire logic tap_otp_wr_i,
  input wire logic tap_otp_sec_row_i,
  input wire logic [OTP_AW-1:0] tap_otp_addr_i,
  input wire logic [31:0] tap_otp_wdata_i,
  output logic tap_otp_rd_grant_o,
  output logic tap_otp_wr_grant_o,
  output logic [31:0] user_identity_code_o,
  // System switch
  input wire logic link_req_i,
  output logic link_grant_o,
  // Tile port access
  input wire logic [23:0] res_id_i,
  input wire logic res_rd_i,
  input wire logic res_wr_i,
  input wire logic [31:0] res_wdata_i,
  output logic res_ack_o,
  output logic [31:0] res_rdata_o,
  output logic [USER_W-1:0] user_data_o
);
  otp_policy_if pif ();
  logic [31:0] word;
  logic valid;
  logic dbg_meta;
  logic dbg_sync;
  logic [CTRL_W-1:0] ctrl;
  logic refused;
  logic data_wr;
  logic ctrl_wr;
  logic hit;
  logic sw_prog_ok;
  logic tap_prog_ok;

  otp_boot_seq #(
    .INIT_LIMIT(INIT_LIMIT)
  ) u_seq (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .pll_lock_i(pll_lock_i),
    .otp_rd_req_o(otp_rd_req_o),
    .otp_rd_addr_o(otp_rd_addr_o),
    .otp_rd_data_i(otp_rd_data_i),
    .otp_rd_valid_i(otp_rd_valid_i),
    .pol(pif.seq)
  );

  assign word = pif.sec_word;
  assign valid = pif.valid;

  // sector lock, master lock covers the security row too
  function automatic logic prog_locked(input logic [31:0] w, input logic [OTP_AW-1:0] a,
                                       input logic sec_row);
    logic [SECTORS-1:0] locks;
    locks = w[BIT_SECT_LOCK_LO +: SECTORS];
    prog_locked = w[BIT_MASTER_LOCK] | (!sec_row && locks[a[OTP_AW-1 -: 2]]);
  endfunction

  // asynchronous active-low reset
  // Debug pin is asynchronous to clk_i
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dbg_meta <= 1'b0;
      dbg_sync <= 1'b0;
    end else begin
      dbg_meta <= debug_req_pin_i;
      dbg_sync <= dbg_meta;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      debug_req_o <= 1'b0;
    end else begin
      debug_req_o <= dbg_sync & valid & ~word[BIT_NO_DEBUG];
    end
  end

  assign tap_tile_grant_o = tap_tile_req_i & valid & ~word[BIT_NO_TAP];
  assign link_grant_o = link_req_i & valid & ~word[BIT_NO_LINK];
  assign tap_otp_rd_grant_o = tap_otp_rd_i & valid & ~word[BIT_NO_TAP_OTP];
  assign tap_prog_ok = valid & ~word[BIT_NO_TAP_OTP]
                     & ~prog_locked(word, tap_otp_addr_i, tap_otp_sec_row_i);
  assign tap_otp_wr_grant_o = tap_otp_wr_i & tap_prog_ok;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      boot_start_o <= 1'b0;
      boot_from_otp_o <= 1'b0;
      otp_redundancy_en_o <= 1'b0;
    end else begin
      boot_start_o <= pif.boot_pulse;
      boot_from_otp_o <= valid & word[BIT_SEC_BOOT];
      otp_redundancy_en_o <= valid & word[BIT_REDUNDANT];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      user_data_o <= '0;
      user_identity_code_o <= '0;
    end else begin
      user_data_o <= word[USER_HI:USER_LO];
      user_identity_code_o <= {word[UID_HI:UID_LO], UID_BASE[UID_LO-1:0]};
    end
  end

  assign data_wr = res_wr_i && (res_id_i == RES_OTP_DATA);
  assign ctrl_wr = res_wr_i && (res_id_i == RES_OTP_CTRL);
  assign hit = (res_id_i == RES_OTP_DATA) || (res_id_i == RES_OTP_CTRL);
  assign sw_prog_ok = valid & ~prog_locked(word, ctrl[OTP_AW-1:0], ctrl[CTRL_SEC_ROW]);

  // Control port holds target address and row select
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl <= '0;
    end else if (ctrl_wr) begin
      ctrl <= res_wdata_i[CTRL_W-1:0];
    end
  end

  // Refusal is sticky; a new refusal wins over the clearing write
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      refused <= 1'b0;
    end else if ((data_wr && !sw_prog_ok) || (tap_otp_wr_i && !tap_prog_ok)) begin
      refused <= 1'b1;
    end else if (ctrl_wr) begin
      refused <= 1'b0;
    end
  end

  // programming issue, software first, test port second
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      otp_prog_req_o <= 1'b0;
      otp_prog_sec_row_o <= 1'b0;
      otp_prog_addr_o <= '0;
      otp_prog_data_o <= '0;
    end else begin
      otp_prog_req_o <= (data_wr && sw_prog_ok) || tap_otp_wr_grant_o;
      if (data_wr && sw_prog_ok) begin
        otp_prog_sec_row_o <= ctrl[CTRL_SEC_ROW];
        otp_prog_addr_o <= ctrl[OTP_AW-1:0];
        otp_prog_data_o <= res_wdata_i;
      end else if (tap_otp_wr_grant_o) begin
        otp_prog_sec_row_o <= tap_otp_sec_row_i;
        otp_prog_addr_o <= tap_otp_addr_i;
        otp_prog_data_o <= tap_otp_wdata_i;
      end
    end
  end

  // Reads answer one cycle later; unknown ids read zero
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      res_ack_o <= 1'b0;
      res_rdata_o <= '0;
    end else begin
      res_ack_o <= res_rd_i | res_wr_i;
      if (res_rd_i && res_id_i == RES_OTP_DATA) begin
        res_rdata_o <= word;
      end else if (res_rd_i && res_id_i == RES_OTP_CTRL) begin
        res_rdata_o <= {16'h0000, ctrl[CTRL_W-1:2], refused, valid};
      end else if (res_rd_i && !hit) begin
        res_rdata_o <= '0;
      end
    end
  end
endmodule

// >>> otp_policy_checker.sv
/* Assertions on the OTP lock policy ports.
   Assumes one clock and the bind below. */
module otp_policy_checker
  import otp_policy_pkg::*;
#(parameter int unsigned INIT_LIMIT = INIT_CYCLES) (
  // Clock, reset, lock
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic pll_lock_i,
  // OTP and boot
  input wire logic otp_rd_req_o,
  input wire logic [31:0] otp_rd_data_i,
  input wire logic otp_rd_valid_i,
  input wire logic otp_prog_req_o,
  input wire logic otp_redundancy_en_o,
  input wire logic boot_start_o,
  input wire logic debug_req_o,
  // Access requests and grants
  input wire logic tap_tile_req_i,
  input wire logic tap_tile_grant_o,
  input wire logic tap_otp_rd_i,
  input wire logic tap_otp_rd_grant_o,
  input wire logic link_req_i,
  input wire logic link_grant_o,
  input wire logic res_rd_i,
  input wire logic res_wr_i,
  input wire logic res_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] w;
  logic [2:0] ld;
  int unsigned cyc;
  logic booted;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_word_taken;
    otp_rd_valid_i && otp_rd_req_o;
  endsequence
  // Slack of two edges so the latency of the policy valid is not assumed
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      w <= 32'h0;
      ld <= 3'h0;
    end else begin
      if (otp_rd_valid_i && otp_rd_req_o) w <= otp_rd_data_i;
      ld <= {ld[1:0], ld[0] | (otp_rd_valid_i & otp_rd_req_o)};
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cyc <= 0;
      booted <= 1'b0;
    end else begin
      if (!booted) cyc <= cyc + 1;
      if (boot_start_o) booted <= 1'b1;
    end
  end
  a_reset_quiet: assert property (disable iff (1'b0) !arst_n_i |-> !boot_start_o && !link_grant_o)
    else $error("outputs active in reset");
  a_lock_first: assert property ($rose(otp_rd_req_o) |-> $past(pll_lock_i, 2))
    else $error("word read before lock");
  a_boot_deadline: assert property (!booted |-> cyc <= INIT_LIMIT)
    else $error("boot too late");
  a_word_boot: assert property (s_word_taken |-> ##[1:3] boot_start_o)
    else $error("no boot after word");
  a_boot_once: assert property (boot_start_o |=> !boot_start_o [*8])
    else $error("boot repeated");
  a_tile_gate: assert property (ld[2] |-> tap_tile_grant_o == (tap_tile_req_i && !w[0]))
    else $error("tile grant wrong");
  a_link_gate: assert property (ld[2] |-> link_grant_o == (link_req_i && !w[1]))
    else $error("link grant wrong");
  a_tap_otp_gate: assert property (ld[2] |-> tap_otp_rd_grant_o == (tap_otp_rd_i && !w[13]))
    else $error("otp read grant wrong");
  a_debug_gate: assert property (ld[2] && w[14] |-> !debug_req_o)
    else $error("debug pin passed");
  a_master_lock: assert property (ld[2] && w[12] |-> !otp_prog_req_o)
    else $error("program while locked");
  a_redund_en: assert property (ld[2] |-> otp_redundancy_en_o == w[7])
    else $error("redundancy wrong");
  a_port_ack: assert property ((res_rd_i || res_wr_i) |=> res_ack_o)
    else $error("no port ack");
endmodule
bind otp_security_lock_policy otp_policy_checker #(.INIT_LIMIT(INIT_LIMIT)) chk_i (.*);

// >>> otp_array_model.sv
/* OTP array answering the security word read.
   Assumes the bench sets word and mute before reset release. */
module otp_array_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Stored word, silence fault
  input wire logic [31:0] word_i,
  input wire logic mute_i,
  // Read port
  input wire logic rd_req_i,
  output logic [31:0] rd_data_o,
  output logic rd_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_cnt;
  // Slow answer; data is inverted outside the valid cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_cnt <= 3'h0;
      rd_valid_o <= 1'b0;
      rd_data_o <= 32'h0;
    end else begin
      rd_valid_o <= 1'b0;
      rd_data_o <= ~word_i;
      if (rd_req_i && !mute_i && !rd_valid_o) begin
        wait_cnt <= wait_cnt + 3'h1;
        if (wait_cnt == 3'h4) begin
          rd_valid_o <= 1'b1;
          rd_data_o <= word_i;
        end
      end
    end
  end
endmodule

// >>> otp_security_lock_policy_test.sv
/* Self-checking bench for the OTP lock policy.
   Assumes the OTP model above on the read port. */
module otp_security_lock_policy_test
  import otp_policy_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned LIM = 64;
  // Reset first falls at a clock edge, so the design sees a real event
  logic clk = 1'b1;
  logic arst_n = 1'b1;
  logic pin = 1'b1;
  logic tap_wr = 1'b0;
  logic [10:0] tap_addr = 11'h0;
  logic tap_wgnt;
  logic [10:0] rd_addr;
  logic pll = 1'b0;
  logic mute = 1'b0;
  logic [31:0] word = 32'h0;
  logic [23:0] res_id = 24'h0;
  logic res_rd = 1'b0;
  logic res_wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic rd_req, rd_valid, prog, prow, redund, boot, from_otp, dbg, tile, otp_rd, link, ack;
  logic [10:0] paddr;
  logic [31:0] rd_data, pdata, uid, rdata;
  logic [6:0] user;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  typedef struct packed {
    logic [31:0] w;
    logic tile, link, otp, dbg;
  } row_s;
  row_s rows [5] = '{'{32'h0, 1'b1, 1'b1, 1'b1, 1'b1}, '{32'h1, 1'b0, 1'b1, 1'b1, 1'b1},
    '{32'h2002, 1'b1, 1'b0, 1'b0, 1'b1}, '{32'hffc0_40a0, 1'b1, 1'b1, 1'b1, 1'b0},
    '{32'h003f_8000, 1'b1, 1'b1, 1'b1, 1'b1}};
  otp_security_lock_policy #(.INIT_LIMIT(LIM)) uut (.clk_i(clk), .arst_n_i(arst_n),
    .pll_lock_i(pll), .debug_req_pin_i(pin), .otp_rd_req_o(rd_req), .otp_rd_addr_o(rd_addr),
    .otp_rd_data_i(rd_data), .otp_rd_valid_i(rd_valid), .otp_prog_req_o(prog),
    .otp_prog_sec_row_o(prow), .otp_prog_addr_o(paddr), .otp_prog_data_o(pdata),
    .otp_redundancy_en_o(redund), .boot_start_o(boot), .boot_from_otp_o(from_otp),
    .debug_req_o(dbg), .tap_tile_req_i(1'b1), .tap_tile_grant_o(tile), .tap_otp_rd_i(1'b1),
    .tap_otp_wr_i(tap_wr), .tap_otp_sec_row_i(1'b0), .tap_otp_addr_i(tap_addr),
    .tap_otp_wdata_i(32'h0), .tap_otp_rd_grant_o(otp_rd), .tap_otp_wr_grant_o(tap_wgnt),
    .user_identity_code_o(uid), .link_req_i(1'b1), .link_grant_o(link), .res_id_i(res_id),
    .res_rd_i(res_rd), .res_wr_i(res_wr), .res_wdata_i(wdata), .res_ack_o(ack),
    .res_rdata_o(rdata), .user_data_o(user));
  otp_array_model model (.clk_i(clk), .arst_n_i(arst_n), .word_i(word), .mute_i(mute),
    .rd_req_i(rd_req), .rd_data_o(rd_data), .rd_valid_o(rd_valid));
  always #2 clk = ~clk;
  task automatic end_sim();
    if (n_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic start(logic [31:0] w, logic m);
    @(negedge clk);
    arst_n = 1'b0;
    pll = 1'b0;
    word = w;
    mute = m;
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    repeat (8) @(negedge clk);
    chk("rd_req", rd_req, 0);
    pll = 1'b1;
    for (int i = 0; i < LIM && !boot; i++) @(negedge clk);
    chk("boot", boot, 1);
    repeat (4) @(negedge clk);
  endtask
  task automatic wr(logic [23:0] id, logic [31:0] d);
    res_id = id;
    wdata = d;
    res_wr = 1'b1;
    @(negedge clk);
  endtask
  // Control write then data write, back to back
  task automatic try_prog(logic [10:0] a, logic row, logic ok);
    logic seen;
    seen = 1'b0;
    wr(RES_OTP_CTRL, {16'h0, row, 4'h0, a});
    wr(RES_OTP_DATA, {21'h0, a});
    res_wr = 1'b0;
    repeat (4) begin
      if (prog === 1'b1) begin
        seen = 1'b1;
        chk("prog_addr", {prow, paddr, pdata[10:0]}, {row, a, a});
      end
      @(negedge clk);
    end
    chk("prog_req", seen, ok);
    res_id = RES_OTP_CTRL;
    res_rd = 1'b1;
    @(negedge clk);
    res_rd = 1'b0;
    for (int i = 0; i < 3 && ack !== 1'b1; i++) @(negedge clk);
    chk("refused", rdata[STAT_REFUSED], !ok);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  initial begin
    foreach (rows[k]) begin
      start(rows[k].w, 1'b0);
      chk("grants", {tile, link, otp_rd, dbg}, rows[k][3:0]);
      chk("boot_otp", {redund, from_otp}, {rows[k].w[7], rows[k].w[5]});
      chk("user", user, rows[k].w[21:15]);
      chk("uid", uid[31:22], rows[k].w[31:22]);
    end
    // Pin passes through when not disabled
    pin = 1'b0;
    repeat (3) @(negedge clk);
    chk("dbg_pin", dbg, 0);
    pin = 1'b1;
    chk("rd_addr", rd_addr, SEC_WORD_ADDR);
    start(32'h0000_0b00, 1'b0);
    try_prog(11'h000, 1'b0, 1'b0);
    try_prog(11'h200, 1'b0, 1'b0);
    try_prog(11'h400, 1'b0, 1'b1);
    try_prog(11'h600, 1'b0, 1'b0);
    try_prog(11'h000, 1'b1, 1'b1);
    // Test-port writes obey the same sector locks
    tap_addr = 11'h400;
    tap_wr = 1'b1;
    #1;
    chk("tap_grant", tap_wgnt, 1);
    @(negedge clk);
    tap_addr = 11'h000;
    chk("tap_prog", {prog, paddr}, {1'b1, 11'h400});
    #1;
    chk("tap_lock", tap_wgnt, 0);
    @(negedge clk);
    tap_wr = 1'b0;
    chk("tap_prog_lock", prog, 0);
    start(32'h0000_1000, 1'b0);
    try_prog(11'h400, 1'b0, 1'b0);
    try_prog(11'h7ff, 1'b1, 1'b0);
    // Silent OTP: boot still comes, with protections on
    start(32'h0, 1'b1);
    chk("failsafe", {tile, link}, 0);
    arst_n = 1'b0;
    #1;
    chk("async_rst", {tile, boot, uid[21:0]}, 0);
    end_sim();
  end
endmodule
